//--- common/ffs_pkg.sv
// Package with offsets, bit positions and carrier types for fault status flags
package ffs_pkg;

  localparam logic [7:0] FFS_OFF_MON_FAULT  = 8'h00;
  localparam logic [7:0] FFS_OFF_SUPPLY_REF = 8'h01;

  // Bit positions in monitor_fault_status
  localparam int FFS_B0_MONITOR_INPUT_5 = 0;
  localparam int FFS_B0_MONITOR_INPUT_4 = 1;
  localparam int FFS_B0_OCP_TIMEOUT     = 5;
  localparam int FFS_B0_UNDERVOLT       = 6;
  localparam int FFS_B0_OVERVOLT        = 7;

  // Bit positions in supply_reference_status
  localparam int FFS_B1_SUPPLY_OV  = 0;
  localparam int FFS_B1_EXT_REF_OK = 1;
  localparam int FFS_B1_INT_REF_OK = 2;

  // Reset images: ok flags read high, fault flags low
  localparam logic [7:0] FFS_RST_MON_FAULT  = 8'h00;
  localparam logic [7:0] FFS_RST_SUPPLY_REF = 8'h06;
  localparam logic [7:0] FFS_UNMAPPED_DATA  = 8'h00;

  // Overcurrent timeout, arbitrary default in clock cycles
  localparam int FFS_OCP_TIMEOUT_CYC = 100;

  localparam int FFS_NUM_MON = 5;

  // Raw condition inputs from the analog detectors
  typedef struct packed {
    logic [FFS_NUM_MON-1:0] monitor;   // Index 0 is monitor_input_1
    logic                   overcurrent;
    logic                   undervoltage;
    logic                   overvoltage;
    logic                   vdd_overvoltage;
    logic                   extref_overload;
    logic                   intref_fail;
  } ffs_cond_t;

  // Register access port from the serial management engine
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
    logic       rd;
  } ffs_req_t;

endpackage : ffs_pkg

//--- rtl/ffs_ocp_timer.sv
// Overcurrent persistence timer producing the timed-out indication
module ffs_ocp_timer #(
  parameter int TIMEOUT_CYC = ffs_pkg::FFS_OCP_TIMEOUT_CYC
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic overcurrent,
  output logic      timed_out
);

  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYC - 1);

  if (TIMEOUT_CYC < 1) begin : g_chk
    $error("TIMEOUT_CYC must be at least one");
  end

  typedef enum logic [2:0] {
    FFS_T_IDLE    = 3'h1,
    FFS_T_COUNT   = 3'h2,
    FFS_T_EXPIRED = 3'h4
  } ffs_tstate_t;

  ffs_tstate_t   state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      FFS_T_IDLE: begin
        if (overcurrent) begin
          cnt_nxt   = CW'(1);
          state_nxt = (TIMEOUT_CYC == 1) ? FFS_T_EXPIRED : FFS_T_COUNT;
        end
      end
      FFS_T_COUNT: begin
        if (!overcurrent) begin
          cnt_nxt   = '0;
          state_nxt = FFS_T_IDLE;
        end else if (cnt_r == LAST) begin
          state_nxt = FFS_T_EXPIRED;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      FFS_T_EXPIRED: begin
        // Flag is live, drops as soon as the overcurrent clears
        if (!overcurrent) begin
          cnt_nxt   = '0;
          state_nxt = FFS_T_IDLE;
        end
      end
      default: begin
        cnt_nxt   = '0;
        state_nxt = FFS_T_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= FFS_T_IDLE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign timed_out = (state_r == FFS_T_EXPIRED);

  // Helper: consecutive overcurrent cycles seen so far, saturating
  logic [CW:0] h_run_r, h_run_nxt;

  always_comb begin
    h_run_nxt = h_run_r;
    if (!overcurrent) begin
      h_run_nxt = '0;
    end else if (h_run_r <= (CW+1)'(TIMEOUT_CYC)) begin
      h_run_nxt = h_run_r + (CW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      h_run_r <= '0;
    end else begin
      h_run_r <= h_run_nxt;
    end
  end

  property p_ocp_expiry;
    @(posedge clk) disable iff (reset)
      timed_out == (h_run_r >= (CW+1)'(TIMEOUT_CYC));
  endproperty
  a_ocp_expiry: assert property (p_ocp_expiry)
    else $error("Overcurrent timeout flag disagrees with run length");

endmodule : ffs_ocp_timer

//--- rtl/ffs_status_regs.sv
// Read-only monitor and fault status registers with register access port
module ffs_status_regs #(
  parameter int OCP_TIMEOUT_CYC = ffs_pkg::FFS_OCP_TIMEOUT_CYC
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire ffs_pkg::ffs_cond_t cond,
  input  wire ffs_pkg::ffs_req_t  req,
  output logic [7:0]              reg_rdata,
  output logic                    reg_rvalid,
  output logic [7:0]              monitor_fault_status,
  output logic [7:0]              supply_reference_status
);

  if (OCP_TIMEOUT_CYC < 1) begin : g_chk
    $error("OCP_TIMEOUT_CYC must be at least one");
  end

  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] off);
    return a == off;
  endfunction : addr_is

  logic       ocp_timed_out;
  logic [7:0] img0_r, img0_nxt;
  logic [7:0] img1_r, img1_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       rvalid_r, rvalid_nxt;

  ffs_ocp_timer #(
    .TIMEOUT_CYC (OCP_TIMEOUT_CYC)
  ) u_ocp_timer (
    .clk         (clk),
    .reset       (reset),
    .overcurrent (cond.overcurrent),
    .timed_out   (ocp_timed_out)
  );

  // Images track their sources every cycle; the write port has no path in
  always_comb begin
    img0_nxt = 8'h00;
    img1_nxt = 8'h00;
    img0_nxt[ffs_pkg::FFS_B0_MONITOR_INPUT_5] = cond.monitor[4];
    for (int i = 0; i < 4; i++) begin
      img0_nxt[ffs_pkg::FFS_B0_MONITOR_INPUT_4 + i] =
          cond.monitor[3-i];
    end
    img0_nxt[ffs_pkg::FFS_B0_OCP_TIMEOUT] = ocp_timed_out;
    img0_nxt[ffs_pkg::FFS_B0_UNDERVOLT]   = cond.undervoltage;
    img0_nxt[ffs_pkg::FFS_B0_OVERVOLT]    = cond.overvoltage;
    img1_nxt[ffs_pkg::FFS_B1_SUPPLY_OV]  = cond.vdd_overvoltage;
    img1_nxt[ffs_pkg::FFS_B1_EXT_REF_OK] = !cond.extref_overload;
    img1_nxt[ffs_pkg::FFS_B1_INT_REF_OK] = !cond.intref_fail;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      img0_r <= ffs_pkg::FFS_RST_MON_FAULT;
      img1_r <= ffs_pkg::FFS_RST_SUPPLY_REF;
    end else begin
      img0_r <= img0_nxt;
      img1_r <= img1_nxt;
    end
  end

  // Read path; unmapped addresses return zero rather than stale data
  always_comb begin
    rvalid_nxt = req.rd;
    rdata_nxt  = rdata_r;
    if (req.rd) begin
      if (addr_is(req.addr, ffs_pkg::FFS_OFF_MON_FAULT)) begin
        rdata_nxt = img0_r;
      end else if (addr_is(req.addr, ffs_pkg::FFS_OFF_SUPPLY_REF)) begin
        rdata_nxt = img1_r;
      end else begin
        rdata_nxt = ffs_pkg::FFS_UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata               = rdata_r;
  assign reg_rvalid              = rvalid_r;
  assign monitor_fault_status    = img0_r;
  assign supply_reference_status = img1_r;

  property p_mon_low;
    @(posedge clk) disable iff (reset)
      ##1 (img0_r[4:1] == {$past(cond.monitor[0]), $past(cond.monitor[1]),
                           $past(cond.monitor[2]), $past(cond.monitor[3])});
  endproperty
  a_mon_low: assert property (p_mon_low)
    else $error("Monitor bits 1-4 do not follow inputs four to one");

  property p_monitor_input_5;
    @(posedge clk) disable iff (reset)
      ##1 img0_r[0] == $past(cond.monitor[4]);
  endproperty
  a_monitor_input_5: assert property (p_monitor_input_5)
    else $error("Monitor five bit did not follow its input");

  property p_ocpto;
    @(posedge clk) disable iff (reset)
      !cond.overcurrent |=> ##1 !img0_r[5];
  endproperty
  a_ocpto: assert property (p_ocpto)
    else $error("Overcurrent timeout bit set without overcurrent");

  property p_ocpto_hold;
    @(posedge clk) disable iff (reset)
      (cond.overcurrent [*2] ##0 ocp_timed_out) |=> img0_r[5];
  endproperty
  a_ocpto_hold: assert property (p_ocpto_hold)
    else $error("Overcurrent timeout bit not shown");

  property p_uv;
    @(posedge clk) disable iff (reset)
      cond.undervoltage |=> img0_r[6];
  endproperty
  a_uv: assert property (p_uv)
    else $error("Undervoltage bit not set");

  property p_ov;
    @(posedge clk) disable iff (reset)
      ##1 img0_r[7] == $past(cond.overvoltage);
  endproperty
  a_ov: assert property (p_ov)
    else $error("Overvoltage bit does not follow detector");

  property p_vddov;
    @(posedge clk) disable iff (reset)
      $fell(cond.vdd_overvoltage) |=> !img1_r[0];
  endproperty
  a_vddov: assert property (p_vddov)
    else $error("Supply overvoltage bit did not clear");

  property p_extref;
    @(posedge clk) disable iff (reset)
      ##1 img1_r[1] != $past(cond.extref_overload);
  endproperty
  a_extref: assert property (p_extref)
    else $error("Reference overload bit has wrong polarity");

  property p_intref;
    @(posedge clk) disable iff (reset)
      cond.intref_fail |=> !img1_r[2];
  endproperty
  a_intref: assert property (p_intref)
    else $error("Internal reference bit not low on failure");

  property p_wr_ignored;
    @(posedge clk) disable iff (reset)
      // Sources held across the write, so any image change is the write's
      req.wr ##1 ($stable(cond) && $stable(ocp_timed_out))
        |=> ($stable(img0_r) && $stable(img1_r));
  endproperty
  a_wr_ignored: assert property (p_wr_ignored)
    else $error("Write altered a status register");

  property p_rd_data;
    @(posedge clk) disable iff (reset)
      (req.rd && req.addr == ffs_pkg::FFS_OFF_SUPPLY_REF)
        |=> (reg_rvalid && reg_rdata == $past(img1_r));
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("Read of supply status returned wrong data");

  property p_rd_status0;
    @(posedge clk) disable iff (reset)
      (req.rd && req.addr == ffs_pkg::FFS_OFF_MON_FAULT)
        |=> (reg_rvalid && reg_rdata == $past(img0_r));
  endproperty
  a_rd_status0: assert property (p_rd_status0)
    else $error("Read of monitor status returned wrong data");

  property p_uv_clear;
    @(posedge clk) disable iff (reset)
      !cond.undervoltage |=> !img0_r[6];
  endproperty
  a_uv_clear: assert property (p_uv_clear)
    else $error("Undervoltage bit set without undervoltage");

  property p_vddov_set;
    @(posedge clk) disable iff (reset)
      cond.vdd_overvoltage |=> img1_r[0];
  endproperty
  a_vddov_set: assert property (p_vddov_set)
    else $error("Supply overvoltage bit not set");

  property p_intref_ok;
    @(posedge clk) disable iff (reset)
      !cond.intref_fail |=> img1_r[2];
  endproperty
  a_intref_ok: assert property (p_intref_ok)
    else $error("Internal reference bit low while reference sound");

  property p_wr_no_rvalid;
    @(posedge clk) disable iff (reset)
      (req.wr && !req.rd) |=> !reg_rvalid;
  endproperty
  a_wr_no_rvalid: assert property (p_wr_no_rvalid)
    else $error("Write produced a read response");

  property p_wr_no_rdata;
    @(posedge clk) disable iff (reset)
      (req.wr && !req.rd) |=> $stable(reg_rdata);
  endproperty
  a_wr_no_rdata: assert property (p_wr_no_rdata)
    else $error("Write disturbed the read data");

endmodule : ffs_status_regs

//--- verif/fault_status_flags_bench.sv
// Self-checking bench for the fault status register bank
module fault_status_flags_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // Short timeout keeps the overcurrent cases brief
  localparam int TMO = 3;

  logic               clk;
  logic               reset;
  ffs_pkg::ffs_cond_t cond;
  ffs_pkg::ffs_req_t  req;
  logic [7:0]         reg_rdata;
  logic               reg_rvalid;
  logic [7:0]         mfs;
  logic [7:0]         srs;
  logic [7:0]         rd;
  int                 mismatches;
  int                 checks_done;

  ffs_status_regs #(.OCP_TIMEOUT_CYC(TMO)) uut (
    .clk                     (clk),
    .reset                   (reset),
    .cond                    (cond),
    .req                     (req),
    .reg_rdata               (reg_rdata),
    .reg_rvalid              (reg_rvalid),
    .monitor_fault_status    (mfs),
    .supply_reference_status (srs)
  );

  ffs_host_model host (
    .clk        (clk),
    .req        (req),
    .reg_rdata  (reg_rdata),
    .reg_rvalid (reg_rvalid)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // Two cycles let a new condition reach the image before the read
  task automatic apply_read(input logic [7:0] addr, input logic [7:0] exp,
                            input string what);
    repeat (2) @(negedge clk);
    host.read_reg(addr, rd);
    check(what, rd, exp);
  endtask : apply_read

  initial begin
    #50us;
    mismatches++;
    $display("[FAIL] watchdog expected finish seen timeout");
    wrap_up();
  end

  initial begin
    reset       = 1'b1;
    cond        = '0;
    mismatches  = 0;
    checks_done = 0;
    repeat (12) @(negedge clk);
    check("status0 reset", mfs, ffs_pkg::FFS_RST_MON_FAULT);
    check("status1 reset", srs, ffs_pkg::FFS_RST_SUPPLY_REF);
    reset = 1'b0;
    apply_read(8'h01, 8'h06, "idle status1");
    apply_read(8'h00, 8'h00, "idle status0");
    for (int i = 0; i < 5; i++) begin
      cond.monitor = 5'h01 << i;
      apply_read(8'h00, 8'h10 >> i, "monitor level");
    end
    cond = '0;
    cond.undervoltage = 1'b1;
    apply_read(8'h00, 8'h40, "undervoltage");
    cond = '0;
    cond.overvoltage = 1'b1;
    apply_read(8'h00, 8'h80, "overvoltage");
    cond = '0;
    cond.vdd_overvoltage = 1'b1;
    apply_read(8'h01, 8'h07, "supply overvoltage");
    cond = '0;
    cond.extref_overload = 1'b1;
    apply_read(8'h01, 8'h04, "reference overload");
    cond = '0;
    cond.intref_fail = 1'b1;
    apply_read(8'h01, 8'h02, "reference failure");
    // Overcurrent one edge short of the timeout must not flag
    cond = '0;
    repeat (2) @(negedge clk);
    cond.overcurrent = 1'b1;
    repeat (TMO - 1) @(negedge clk);
    cond.overcurrent = 1'b0;
    repeat (4) begin
      @(negedge clk);
      check("short overcurrent", mfs, 8'h00);
    end
    cond.overcurrent = 1'b1;
    repeat (TMO + 2) @(negedge clk);
    apply_read(8'h00, 8'h20, "overcurrent timed out");
    cond.overcurrent = 1'b0;
    apply_read(8'h00, 8'h00, "overcurrent cleared");
    // Writes of inverted images must leave both registers alone
    cond.undervoltage = 1'b1;
    host.write_reg(8'h00, 8'hBF);
    host.write_reg(8'h01, 8'hF9);
    apply_read(8'h00, 8'h40, "status0 after write");
    apply_read(8'h01, 8'h06, "status1 after write");
    apply_read(8'h02, ffs_pkg::FFS_UNMAPPED_DATA, "unmapped read");
    wrap_up();
  end
endmodule : fault_status_flags_bench

//--- verif/ffs_host_model.sv
// Host side model issuing byte reads and writes on the register port
module ffs_host_model (
  input  wire logic        clk,
  output ffs_pkg::ffs_req_t req,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic        reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  // Strobes last one cycle; address and data are scrambled once released
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    int n;
    n = 0;
    @(negedge clk);
    req.addr = addr;
    req.rd   = 1'b1;
    @(negedge clk);
    req.rd   = 1'b0;
    req.addr = ~addr;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    data = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask : read_reg

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    req.addr  = addr;
    req.wdata = data;
    req.wr    = 1'b1;
    @(negedge clk);
    req.wr    = 1'b0;
    req.addr  = ~addr;
    req.wdata = ~data;
  endtask : write_reg
endmodule : ffs_host_model
